// file: design/ebwbr_ctrl.sv
// Purpose: External bus cycle sequencer: program and pin waits, burst
//   ROM beats, area decode and refresh timing, CAS ahead of RAS only with precharge extension
// Assumes: Config bits arrive on ports and load on I_CFG_WE
// Notes: Outputs are registered; refresh wins over a same-cycle access
//
// Overview of operation
// RL1 - Area 5 with access-state bit set inserts 0-3 waits, reset 3.
// RL2 - Area 4 with access-state bit set inserts 0-3 waits, reset 3.
// RL3 - Burst beat lasts 2 states when length bit clear, 3 when set.
// RL4 - Burst limited to 4 words (above A3) or 8 words (above A4).
// RL5 - Reserved burst control bit 2 is read-only and reads 1.
// RL6 - Area division select acts only in modes 3, 4 and 5.
// RL7 - Division select set: eight equal 2 MB areas.
// RL8 - Division select clear: uneven area sizes from 8 MB down to 22 B.
// RL9 - Wait pin honoured only when enabled; otherwise pin is general I/O.
// RL10 - Refresh is precharge plus two RAS states; precharge one or two.
// RL11 - Precharge extension delays RAS one state; CAS timing unchanged.
// RL12 - RAS width bit inserts one wait between first and second RAS state.
// RL13 - RAS width bit affects only refresh, not read or write cycles.
// RL14 - Refresh length ignores access-state, wait fields and wait pin.
// RL15 - Access-state bit clear means no program waits for that area.
// RL16 - Wait pin held low extends access one state per sample.

`timescale 1ns/1ps
`default_nettype none

module ebwbr_ctrl (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic [2:0] I_MODE,
  input wire logic I_CFG_WE,
  input wire logic I_AREA5_WAIT_HI,
  input wire logic I_AREA5_WAIT_LO,
  input wire logic I_AREA4_WAIT_HI,
  input wire logic I_AREA4_WAIT_LO,
  input wire logic I_AREA5_ACCESS_STATE_SEL,
  input wire logic I_AREA4_ACCESS_STATE_SEL,
  input wire logic I_BURST_CYCLE_LEN_SEL,
  input wire logic I_BURST_WORD_COUNT_SEL,
  input wire logic I_AREA_DIVISION_UNIT_SEL,
  input wire logic I_WAIT_PIN_EN,
  input wire logic I_REFRESH_PRECHARGE_EXTEND,
  input wire logic I_REFRESH_RAS_WIDTH_EXT,
  input wire logic I_ACC_REQ,
  input wire logic [ebwbr_pkg::ADDR_W-1:0] I_ACC_ADDR,
  input wire logic I_ACC_BURST,
  input wire logic I_REF_REQ,
  input wire logic I_WAIT_N,
  output logic O_BUSY,
  output logic O_ACC_ACK,
  output logic [2:0] O_AREA,
  output logic O_AREA_VALID,
  output logic O_REF_DONE,
  output logic O_RAS_N,
  output logic O_UCAS_N,
  output logic O_LCAS_N,
  output logic [ebwbr_pkg::BC_W-1:0] O_BURST_CTRL_RD,
  output logic O_WAIT_PIN_IS_GPIO
);
  import ebwbr_pkg::*;

  typedef struct packed {
    ebwbr_state_e st;
    logic [2:0] sync, beats, area;
    logic [1:0] a5w, a4w, wcnt, scnt;
    logic wait_lvl, area5_access_state_sel, area4_access_state_sel, blen, bcnt, div, wait_pin_en, refresh_precharge_extend, refresh_ras_width_ext;
    logic burst, ack, refdone, avalid, ras_n, cas_n;
  } ebwbr_state_s;

  localparam ebwbr_state_s RST_S = '{
    st: S_IDLE, sync: 3'h7, wait_lvl: 1'b1,
    a5w: WAIT_FIELD_RST, a4w: WAIT_FIELD_RST,
    area5_access_state_sel: AST_RST, area4_access_state_sel: AST_RST, blen: BURST_LEN_RST,
    bcnt: BURST_CNT_RST, div: AREA_DIV_RST, wait_pin_en: WAIT_PIN_EN_RST,
    refresh_precharge_extend: PRECHARGE_EXT_RST, refresh_ras_width_ext: RAS_WIDTH_RST, wcnt: 2'h0,
    scnt: 2'h0, beats: 3'h0, burst: 1'b0, ack: 1'b0, refdone: 1'b0,
    area: 3'h0, avalid: 1'b0, ras_n: 1'b1, cas_n: 1'b1};

  ebwbr_state_s q, d;

  // ----------------------------------------------------------------
  // Area decode
  // ----------------------------------------------------------------
  logic div_eff, valid_c, pin_wait;
  logic [2:0] area_c, widx_c;
  logic [1:0] pwait_c;

  // RL6 mode gate
  assign div_eff = (I_MODE >= 3'h3 && I_MODE <= 3'h5) ? q.div : 1'b1;

  always_comb begin
    area_c = I_ACC_ADDR[AREA_MSB:AREA_LSB];
    valid_c = 1'b1;
    if (!div_eff) begin
      // RL8 uneven map; gaps above area 6 are on-chip space
      if (I_ACC_ADDR < A1_BASE) begin
        area_c = 3'h0;
      end else if (I_ACC_ADDR < A2_BASE) begin
        area_c = 3'h1;
      end else if (I_ACC_ADDR < A3_BASE) begin
        area_c = 3'h2;
      end else if (I_ACC_ADDR < A4_BASE) begin
        area_c = 3'h3;
      end else if (I_ACC_ADDR < A5_BASE) begin
        area_c = 3'h4;
      end else if (I_ACC_ADDR < A6_BASE) begin
        area_c = 3'h5;
      end else if (I_ACC_ADDR <= A6_END) begin
        area_c = 3'h6;
      end else if (I_ACC_ADDR >= A7_BASE && I_ACC_ADDR <= A7_END) begin
        area_c = 3'h7;
      end else begin
        valid_c = 1'b0;
      end
    end
  end

  // RL1 RL2 RL15 program wait select
  always_comb begin
    pwait_c = 2'h0;
    if (valid_c && area_c == AREA_5 && q.area5_access_state_sel) begin
      pwait_c = q.a5w;
    end else if (valid_c && area_c == AREA_4 && q.area4_access_state_sel) begin
      pwait_c = q.a4w;
    end
  end

  // RL4 word index within the aligned block
  assign widx_c = q.bcnt ? I_ACC_ADDR[3:1] : {1'b0, I_ACC_ADDR[2:1]};

  // RL9 RL16 pin waits only when enabled
  assign pin_wait = q.wait_pin_en && !q.wait_lvl;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.refdone = 1'b0;
    d.sync = {q.sync[1:0], I_WAIT_N};
    // Level counts only once second and third stages agree
    if (q.sync[2] == q.sync[1]) begin
      d.wait_lvl = q.sync[2];
    end
    if (I_CFG_WE) begin
      d.a5w = {I_AREA5_WAIT_HI, I_AREA5_WAIT_LO};
      d.a4w = {I_AREA4_WAIT_HI, I_AREA4_WAIT_LO};
      d.area5_access_state_sel = I_AREA5_ACCESS_STATE_SEL;
      d.area4_access_state_sel = I_AREA4_ACCESS_STATE_SEL;
      d.blen = I_BURST_CYCLE_LEN_SEL;
      d.bcnt = I_BURST_WORD_COUNT_SEL;
      d.div = I_AREA_DIVISION_UNIT_SEL;
      d.wait_pin_en = I_WAIT_PIN_EN;
      d.refresh_precharge_extend = I_REFRESH_PRECHARGE_EXTEND;
      d.refresh_ras_width_ext = I_REFRESH_RAS_WIDTH_EXT;
    end
    unique case (q.st)
      S_IDLE: begin
        if (I_REF_REQ) begin
          d.st = S_RP;
        end else if (I_ACC_REQ) begin
          d.st = S_T1;
          // RL7 equal areas fall out of the top address bits
          d.area = area_c;
          d.avalid = valid_c;
          d.wcnt = pwait_c;
          d.burst = I_ACC_BURST && valid_c && area_c == AREA_BURST_ROM;
          d.beats = (q.bcnt ? LAST_WORD_8 : LAST_WORD_4) - widx_c;
        end
      end
      S_T1: d.st = (q.wcnt != 2'h0) ? S_TW : S_T2;
      S_TW: begin
        d.wcnt = q.wcnt - 2'h1;
        if (q.wcnt == 2'h1) begin
          d.st = S_T2;
        end
      end
      S_T2: begin
        if (!pin_wait) begin
          d.ack = 1'b1;
          if (q.burst && q.beats != 3'h0) begin
            d.st = S_BR;
            // RL3 beat length
            d.scnt = q.blen ? BEAT_LONG_M1 : BEAT_SHORT_M1;
          end else begin
            d.st = S_IDLE;
          end
        end
      end
      S_BR: begin
        if (q.scnt == 2'h0) begin
          d.ack = 1'b1;
          d.beats = q.beats - 3'h1;
          d.scnt = q.blen ? BEAT_LONG_M1 : BEAT_SHORT_M1;
          // RL4 stop at block end
          if (q.beats == 3'h1) begin
            d.st = S_IDLE;
          end
        end else begin
          d.scnt = q.scnt - 2'h1;
        end
      end
      // RL10 RL14 fixed refresh walk, no wait sources consulted
      S_RP: begin
        d.cas_n = 1'b0;
        // RL11 RAS held off one more state
        if (q.refresh_precharge_extend) begin
          d.st = S_RP2;
        end else begin
          d.st = S_R1;
          d.ras_n = 1'b0;
        end
      end
      S_RP2: begin
        d.st = S_R1;
        d.ras_n = 1'b0;
      end
      // RL12 RL13 RAS width wait only on the refresh path
      S_R1: d.st = q.refresh_ras_width_ext ? S_RW : S_R2;
      S_RW: d.st = S_R2;
      S_R2: begin
        d.st = S_IDLE;
        d.ras_n = 1'b1;
        d.cas_n = 1'b1;
        d.refdone = 1'b1;
      end
      default: d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      q <= RST_S;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_BUSY = (q.st != S_IDLE);
  assign O_ACC_ACK = q.ack;
  assign O_AREA = q.area;
  assign O_AREA_VALID = q.avalid;
  assign O_REF_DONE = q.refdone;
  assign O_RAS_N = q.ras_n;
  assign O_UCAS_N = q.cas_n;
  assign O_LCAS_N = q.cas_n;
  // RL5 reserved bit fixed high
  assign O_BURST_CTRL_RD = {q.blen, q.bcnt, BC_RSV_VAL, q.div, q.wait_pin_en};
  assign O_WAIT_PIN_IS_GPIO = !q.wait_pin_en;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  sequence ref_short_s;
    (q.st == S_R1) ##1 (q.st == S_R2) ##1 (q.st == S_IDLE && q.refdone);
  endsequence
  sequence ref_long_s;
    (q.st == S_R1) ##1 (q.st == S_RW) ##1 (q.st == S_R2) ##1 q.refdone;
  endsequence

  area5_wait_a: assert property ( // RL1
    q.st == S_T1 && q.area == AREA_5 && q.area5_access_state_sel && q.a5w == 2'h3 &&
    !q.wait_pin_en && !I_CFG_WE |=> (q.st == S_TW) [*3] ##1 (q.st == S_T2)
    ##1 q.ack) else $error("area 5 wait count wrong");
  area4_nowait_a: assert property ( // RL15
    $rose(q.st == S_T1) && q.area == AREA_4 && !$past(q.area4_access_state_sel) |->
    q.wcnt == 2'h0) else $error("area 4 waits without access state");
  beat_len_a: assert property ( // RL3
    q.ack && q.st == S_BR && q.blen && q.beats != 3'h0 && !I_CFG_WE |=>
    !q.ack [*2] ##1 q.ack) else $error("long burst beat length wrong");
  rsv_bit_a: assert property ( // RL5
    O_BURST_CTRL_RD[BC_RSV_POS] == 1'b1) else $error("reserved bit low");
  div_mode_a: assert property ( // RL6
    q.st == S_IDLE && !I_REF_REQ && I_ACC_REQ && I_MODE > 3'h5 |=>
    q.area == $past(I_ACC_ADDR[AREA_MSB:AREA_LSB]) && q.avalid)
    else $error("division select used outside modes 3 to 5");
  pin_off_a: assert property ( // RL9
    q.st == S_T2 && !q.wait_pin_en |=> q.st != S_T2)
    else $error("wait pin honoured while disabled");
  pin_hold_a: assert property ( // RL16
    q.st == S_T2 && pin_wait |=> q.st == S_T2 && !q.ack)
    else $error("pin wait not extending access");
  ref_base_a: assert property ( // RL10
    q.st == S_RP && !q.refresh_precharge_extend && !q.refresh_ras_width_ext && !I_CFG_WE |=> ref_short_s)
    else $error("basic refresh walk wrong");
  tpc_delay_a: assert property ( // RL11
    q.st == S_RP && q.refresh_precharge_extend |=> (!q.cas_n && q.ras_n) ##1
    (!q.cas_n && !q.ras_n)) else $error("precharge extension wrong");
  ras_width_a: assert property ( // RL12
    q.st == S_R1 && q.refresh_ras_width_ext && !I_CFG_WE |-> ref_long_s)
    else $error("RAS width wait missing");

endmodule

`default_nettype wire

// file: design/ebwbr_pkg.sv
// Purpose: Constants and types for the external bus wait/burst/refresh block
// Assumes: 24-bit external address space, 100 MHz system clock
// Notes: Area bounds for the fine division map live here

package ebwbr_pkg;

  // ----------------------------------------------------------------
  // Reset values of the configuration bits
  // ----------------------------------------------------------------
  localparam logic [1:0] WAIT_FIELD_RST = 2'h3;
  localparam logic AST_RST = 1'b1;
  localparam logic BURST_LEN_RST = 1'b0;
  localparam logic BURST_CNT_RST = 1'b0;
  localparam logic AREA_DIV_RST = 1'b1;
  localparam logic WAIT_PIN_EN_RST = 1'b0;
  localparam logic PRECHARGE_EXT_RST = 1'b0;
  localparam logic RAS_WIDTH_RST = 1'b0;

  // ----------------------------------------------------------------
  // Burst control readback layout
  // ----------------------------------------------------------------
  localparam int BC_W = 5;
  localparam int BC_LEN_POS = 4;
  localparam int BC_CNT_POS = 3;
  localparam int BC_RSV_POS = 2;
  localparam int BC_DIV_POS = 1;
  localparam int BC_WAIT_PIN_EN_POS = 0;
  localparam logic BC_RSV_VAL = 1'b1;

  // ----------------------------------------------------------------
  // Burst timing: states per beat minus one, last word index
  // ----------------------------------------------------------------
  localparam logic [1:0] BEAT_SHORT_M1 = 2'h1;
  localparam logic [1:0] BEAT_LONG_M1 = 2'h2;
  localparam logic [2:0] LAST_WORD_4 = 3'h3;
  localparam logic [2:0] LAST_WORD_8 = 3'h7;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int AREA_MSB = 23;
  localparam int AREA_LSB = 21;
  localparam logic [23:0] A1_BASE = 24'h200000;
  localparam logic [23:0] A2_BASE = 24'h400000;
  localparam logic [23:0] A3_BASE = 24'hC00000;
  localparam logic [23:0] A4_BASE = 24'hE00000;
  localparam logic [23:0] A5_BASE = 24'hFEE000;
  localparam logic [23:0] A6_BASE = 24'hFEF000;
  localparam logic [23:0] A6_END = 24'hFF4EFF;
  localparam logic [23:0] A7_BASE = 24'hFFFF00;
  localparam logic [23:0] A7_END = 24'hFFFF15;
  localparam logic [2:0] AREA_BURST_ROM = 3'h0;
  localparam logic [2:0] AREA_4 = 3'h4;
  localparam logic [2:0] AREA_5 = 3'h5;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_T1 = 4'h1,
    S_TW = 4'h2,
    S_T2 = 4'h3,
    S_BR = 4'h4,
    S_RP = 4'h5,
    S_RP2 = 4'h6,
    S_R1 = 4'h7,
    S_RW = 4'h8,
    S_R2 = 4'h9
  } ebwbr_state_e;

endpackage

// file: tb/ebwbr_mem_model.sv
// Purpose: Far-side memory stand-in that drives the wait pin
// Assumes: Pin has a pull-up, so it idles high
// Notes: Stalls each new cycle from its first state on

`timescale 1ns/1ps
`default_nettype none

module ebwbr_mem_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_busy,
  input wire logic [3:0] i_stall,
  output logic o_wait_n
);
  logic busy_q;
  logic [3:0] cnt_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      busy_q <= i_busy;
      if (i_busy && !busy_q) begin
        cnt_q <= i_stall;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  // Wait drops in the first state, else the pin sync would miss T2
  assign o_wait_n = (cnt_q == 4'h0) &&
    !(i_busy && !busy_q && i_stall != 4'h0);
endmodule

`default_nettype wire

// file: tb/tb.sv
// Purpose: Self-checking bench for the bus cycle sequencer
// Assumes: Stimulus changes by non-blocking assignment, on rising edges or 1 ns after one
// Notes: Pin-wait latency is checked as a range, not an exact count

`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("wrong value t=%0t got %0h exp %0h", $time, g, e); end end

module tb;
  import ebwbr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, req = 1'b0, bst = 1'b0;
  logic rreq = 1'b0;
  logic [2:0] mode = 3'h3;
  logic [11:0] cfg_v = 12'hFC8;
  logic [23:0] addr = 24'h000000;
  logic [3:0] stall = 4'h0;
  logic wait_n, busy, ack, avalid, rdone, ras_n, ucas_n, lcas_n, gpio;
  logic [2:0] area;
  logic [4:0] rd;
  int failures = 0, n_compared = 0, n, k, g, i, j;
  bit sep;

  initial begin
    forever #5 clk = ~clk;
  end

  ebwbr_ctrl ebwbr_ctrl_inst (.I_MCLK(clk), .I_RST_N(rst_n), .I_MODE(mode),
    .I_CFG_WE(we), .I_AREA5_WAIT_HI(cfg_v[11]), .I_AREA5_WAIT_LO(cfg_v[10]),
    .I_AREA4_WAIT_HI(cfg_v[9]), .I_AREA4_WAIT_LO(cfg_v[8]),
    .I_AREA5_ACCESS_STATE_SEL(cfg_v[7]), .I_AREA4_ACCESS_STATE_SEL(cfg_v[6]),
    .I_BURST_CYCLE_LEN_SEL(cfg_v[5]), .I_BURST_WORD_COUNT_SEL(cfg_v[4]),
    .I_AREA_DIVISION_UNIT_SEL(cfg_v[3]), .I_WAIT_PIN_EN(cfg_v[2]),
    .I_REFRESH_PRECHARGE_EXTEND(cfg_v[1]), .I_REFRESH_RAS_WIDTH_EXT(cfg_v[0]),
    .I_ACC_REQ(req), .I_ACC_ADDR(addr), .I_ACC_BURST(bst), .I_REF_REQ(rreq),
    .I_WAIT_N(wait_n), .O_BUSY(busy), .O_ACC_ACK(ack), .O_AREA(area),
    .O_AREA_VALID(avalid), .O_REF_DONE(rdone), .O_RAS_N(ras_n),
    .O_UCAS_N(ucas_n), .O_LCAS_N(lcas_n), .O_BURST_CTRL_RD(rd),
    .O_WAIT_PIN_IS_GPIO(gpio));

  ebwbr_mem_model ebwbr_mem_model_inst (.i_clk(clk), .i_rst_n(rst_n),
    .i_busy(busy), .i_stall(stall), .o_wait_n(wait_n));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  function automatic logic [11:0] mk(logic [1:0] w, logic [1:0] ast,
    logic [5:0] rest);
    return {w, w, ast, rest};
  endfunction

  task automatic cfg(input logic [11:0] v);
    @(posedge clk);
    cfg_v <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    #1;
    `CHK(rd, {v[5], v[4], 1'b1, v[3], v[2]})
    `CHK(gpio, ~v[2])
  endtask

  // Cycles from taking edge to idle, ack count, last ack gap
  task automatic acc(input logic [23:0] a, input logic b);
    int p;
    n = 0;
    k = 0;
    p = 0;
    @(posedge clk);
    req <= 1'b1;
    addr <= a;
    bst <= b;
    @(posedge clk);
    req <= 1'b0;
    while (n < 80) begin
      @(posedge clk);
      #1;
      n++;
      if (ack === 1'b1) begin
        k++;
        g = n - p;
        p = n;
      end
      if (busy === 1'b0) break;
    end
  endtask

  task automatic refr();
    n = 0;
    sep = 1'b0;
    @(posedge clk);
    rreq <= 1'b1;
    @(posedge clk);
    rreq <= 1'b0;
    while (n < 40 && rdone !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (ucas_n === 1'b0 && lcas_n === 1'b0 && ras_n === 1'b1) sep = 1'b1;
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK(rd, 5'h06)
    acc(24'hA00000, 1'b0);
    `CHK(n, 5)
    `CHK(area, 3'h5)
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      cfg(mk(i[1:0], 2'h3, 6'h08));
      acc(24'hA00000, 1'b0);
      `CHK(n, 2 + i)
      acc(24'h800000, 1'b0);
      `CHK(n, 2 + i)
      `CHK(area, 3'h4)
    end
    cfg(mk(2'h3, 2'h0, 6'h08));
    acc(24'hA00000, 1'b0);
    `CHK(n, 2)
    acc(24'h800000, 1'b0);
    `CHK(n, 2)
    cfg(mk(2'h2, 2'h3, 6'h09));
    acc(24'hA00000, 1'b0);
    `CHK(n, 4)
    $display("program wait test done");
    cfg(mk(2'h3, 2'h0, 6'h00));
    for (j = 0; j < 7; j++) begin
      acc(j[2:0] == 3'h6 ? A7_END + 24'h1 : (j == 0 ? A4_BASE :
        j == 1 ? A5_BASE : j == 2 ? A6_END : j == 3 ? A7_END :
        j == 4 ? 24'h600000 : 24'h200000), 1'b0);
      `CHK(avalid, j != 6)
      if (j < 6) `CHK(area, j < 4 ? 3'(j + 4) : 3'(6 - j))
    end
    for (i = 1; i < 8; i++) begin
      mode <= i[2:0];
      acc(24'h600000, 1'b0);
      `CHK(area, (i >= 3 && i <= 5) ? 3'h2 : 3'h3)
    end
    mode <= 3'h3;
    $display("decode test done");
    for (i = 0; i < 4; i++) begin
      cfg(mk(2'h3, 2'h0, {i[1], i[0], 4'h8}));
      acc(24'h000000, 1'b1);
      `CHK(k, i[0] ? 8 : 4)
      `CHK(g, i[1] ? 3 : 2)
    end
    $display("burst test done");
    stall <= 4'h5;
    for (i = 0; i < 4; i++) begin
      cfg(mk(2'h3, 2'h3, {4'h3, i[1], i[0]}));
      refr();
      `CHK(n, 3 + i[1] + i[0])
      `CHK(sep, i[1])
    end
    $display("refresh test done");
    stall <= 4'h4;
    cfg(mk(2'h3, 2'h3, 6'h08));
    acc(24'hA00000, 1'b0);
    `CHK(n, 5)
    cfg(mk(2'h3, 2'h3, 6'h0C));
    acc(24'hA00000, 1'b0);
    `CHK((n > 5) && (n < 14), 1'b1)
    $display("wait pin test done");
    final_report();
  end
endmodule

`default_nettype wire
